// file: dv/fxd_host_model.sv
// fxd_host_model: host or bus master issuing byte-wide i/o cycles.
// assumes one clock and a decoder that takes every offered request.
`timescale 1ns/1ns
module fxd_host_model (
   // clock
   input wire logic clk_sys_i,
   // i/o cycle request
   output logic io_valid_o,
   output logic io_write_o,
   output logic [15:0] io_addr_o,
   output logic [7:0] io_wdata_o
);
   initial
   begin
      io_valid_o = 1'b0;
      io_write_o = 1'b0;
      io_addr_o = 16'hffff;
      io_wdata_o = 8'h00;
   end

   // one request per call; lines inverted after release so stale values never look valid
   task automatic io(input logic wr, input logic [15:0] addr, input logic [7:0] data);
      @(posedge clk_sys_i);
      io_valid_o <= 1'b1;
      io_write_o <= wr;
      io_addr_o <= addr;
      io_wdata_o <= data;
      @(posedge clk_sys_i);
      io_valid_o <= 1'b0;
      io_write_o <= ~wr;
      io_addr_o <= ~addr;
      io_wdata_o <= ~data;
   endtask : io
endmodule : fxd_host_model

// file: dv/tb.sv
// tb: self-checking bench for the fixed i/o range decoder.
// assumes the host model issues cycles and outputs settle 1 ns after the edge.
`timescale 1ns/1ns
module tb;
   logic clk_sys_i, reset_i, ce_i, rtc_ext_fwd_en_i, alias_fwd_en_i;
   logic io_valid_i, io_write_i, done_o, claim_o, forward_o, local_o;
   logic [15:0] io_addr_i;
   logic [7:0] io_wdata_i, rdata_o;
   logic [3:0] second_dma_controller_mask_o;
   fxd_pkg::fxd_tgt_t target_o;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;

   fxd_host_model host (.clk_sys_i(clk_sys_i), .io_valid_o(io_valid_i), .io_write_o(io_write_i),
      .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i));
   fxd_decoder dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .io_valid_i(io_valid_i),
      .io_write_i(io_write_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
      .rtc_ext_fwd_en_i(rtc_ext_fwd_en_i), .alias_fwd_en_i(alias_fwd_en_i), .done_o(done_o),
      .claim_o(claim_o), .forward_o(forward_o), .target_o(target_o), .local_o(local_o),
      .rdata_o(rdata_o), .second_dma_controller_mask_o(second_dma_controller_mask_o));

   initial
   begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         results();
      end
   end

   task automatic results;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic do_reset;
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      repeat (12) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask : do_reset

   task automatic en(input logic r, input logic a);
      @(posedge clk_sys_i);
      rtc_ext_fwd_en_i <= r;
      alias_fwd_en_i <= a;
   endtask : en

   task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic cl,
      input logic fw, input fxd_pkg::fxd_tgt_t t);
      host.io(wr, a, d);
      #1;
      cmp(16'(done_o), 16'h0001);
      cmp(16'(claim_o), 16'(cl));
      cmp(16'(forward_o), 16'(fw));
      cmp(16'(target_o), 16'(t));
   endtask : xfer

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      host.io(1'b0, a, 8'h00);
      #1;
      cmp(16'(rdata_o), 16'(exp));
      cmp(16'(local_o), 16'h0001);
   endtask : rd

   task automatic t_reset_vals;
      cmp(16'(done_o), 16'h0000);
      cmp(16'(claim_o), 16'h0000);
      cmp(16'(second_dma_controller_mask_o), 16'h0001);
      rd(16'h0092, 8'h00);
      rd(16'h00b2, 8'h00);
      rd(16'h00b3, 8'h00);
      rd(16'h04d0, 8'h00);
      rd(16'h04d1, 8'h00);
      rd(16'h00de, 8'h01);
   endtask : t_reset_vals

   task automatic t_rtc;
      en(1'b0, 1'b1);
      xfer(1'b1, 16'h0073, 8'h3c, 1'b1, 1'b0, fxd_pkg::T_RTC_EXT);
      en(1'b1, 1'b0);
      xfer(1'b1, 16'h0073, 8'h3c, 1'b1, 1'b1, fxd_pkg::T_RTC_EXT);
   endtask : t_rtc

   task automatic t_page_rsvd;
      logic [15:0] pg [8] = '{16'h0080, 16'h0084, 16'h0085, 16'h0086, 16'h0088, 16'h008c, 16'h008d, 16'h008e};
      for (int i = 0; i < 8; i++)
      begin
         en(1'b1, 1'b0);
         xfer(1'b1, pg[i], 8'(8'h40 + i), 1'b1, 1'b1, fxd_pkg::T_PAGE_RSVD);
         rd(pg[i], 8'(8'h40 + i));
         xfer(1'b1, pg[i] + 16'h0010, 8'(8'hc0 + i), 1'b1, 1'b0, fxd_pkg::T_PAGE_RSVD);
         en(1'b0, 1'b1);
         xfer(1'b1, pg[i] + 16'h0010, 8'(8'hc0 + i), 1'b1, 1'b1, fxd_pkg::T_PAGE_RSVD);
         xfer(1'b1, pg[i], 8'(8'h40 + i), 1'b1, 1'b1, fxd_pkg::T_PAGE_RSVD);
      end
      // each location must keep its own byte, not a neighbour's
      for (int i = 0; i < 8; i++)
         rd(pg[i], 8'(8'h40 + i));
      host.io(1'b1, 16'h0086, 8'h66);
      @(posedge clk_sys_i);
      rd(16'h0086, 8'h66);
   endtask : t_page_rsvd

   task automatic t_page_low;
      logic [15:0] lp [7] = '{16'h0087, 16'h0083, 16'h0081, 16'h0082, 16'h008b, 16'h0089, 16'h008a};
      en(1'b1, 1'b1);
      for (int i = 0; i < 7; i++)
      begin
         xfer(1'b1, lp[i], 8'h11, 1'b1, 1'b0, fxd_pkg::T_PAGE_LOW);
         if (lp[i] != 16'h0082)
            xfer(1'b1, lp[i] + 16'h0010, 8'h22, 1'b1, 1'b0, fxd_pkg::T_PAGE_LOW);
      end
   endtask : t_page_low

   // fixed ranges other than the rtc port and non-refresh page registers walked by read and write with both forwarding enables on; fast a20 written once
   task automatic t_ranges;
      logic [15:0] b [18] = '{16'h00a0, 16'h00a1, 16'h00c0, 16'h00d0, 16'h00d2, 16'h00d4, 16'h00d6, 16'h00d8,
         16'h00da, 16'h00dc, 16'h00de, 16'h00b2, 16'h01f0, 16'h03f6, 16'h0170, 16'h0376, 16'h04d0, 16'h008f};
      int n [18] = '{8, 8, 16, 2, 2, 2, 2, 2, 2, 2, 2, 2, 8, 1, 8, 1, 2, 2};
      int s [18] = '{4, 4, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 16};
      fxd_pkg::fxd_tgt_t t [18] = '{fxd_pkg::T_PIC2_CTRL, fxd_pkg::T_PIC2_MASK, fxd_pkg::T_SECOND_DMA_CONTROLLER_CHAN,
         fxd_pkg::T_SECOND_DMA_CONTROLLER_CMD_STAT, fxd_pkg::T_SECOND_DMA_CONTROLLER_REQ, fxd_pkg::T_SECOND_DMA_CONTROLLER_SMASK, fxd_pkg::T_SECOND_DMA_CONTROLLER_MODE,
         fxd_pkg::T_SECOND_DMA_CONTROLLER_CLR_PTR, fxd_pkg::T_SECOND_DMA_CONTROLLER_MCLR, fxd_pkg::T_SECOND_DMA_CONTROLLER_CLR_MASK, fxd_pkg::T_SECOND_DMA_CONTROLLER_AMASK,
         fxd_pkg::T_PWR_MGMT, fxd_pkg::T_DISK_PRI, fxd_pkg::T_DISK_PRI, fxd_pkg::T_DISK_SEC,
         fxd_pkg::T_DISK_SEC, fxd_pkg::T_ELCR, fxd_pkg::T_PAGE_REFRESH};
      en(1'b1, 1'b1);
      for (int i = 0; i < 18; i++)
         for (int j = 0; j < n[i]; j++)
            for (int w = 0; w < 2; w++)
               xfer(1'(w), b[i] + 16'(j * s[i]), 8'h00, 1'b1, 1'b0, t[i]);
      xfer(1'b1, 16'h0092, 8'h00, 1'b1, 1'b0, fxd_pkg::T_FAST_A20);
   endtask : t_ranges

   task automatic t_unclaimed;
      logic [15:0] u [9] = '{16'h00a2, 16'h00b6, 16'h01f8, 16'h03f7, 16'h04d2, 16'h0378, 16'h0100, 16'hffff,
         16'h0300};
      en(1'b1, 1'b1);
      for (int i = 0; i < 9; i++)
         xfer(1'b1, u[i], 8'h5a, 1'b0, 1'b0, fxd_pkg::T_NONE);
      cmp(16'(local_o), 16'h0000);
   endtask : t_unclaimed

   task automatic t_second_dma_controller;
      xfer(1'b1, 16'h00de, 8'h0a, 1'b1, 1'b0, fxd_pkg::T_SECOND_DMA_CONTROLLER_AMASK);
      cmp(16'(second_dma_controller_mask_o), 16'h000a);
      rd(16'h00df, 8'h0a);
      xfer(1'b1, 16'h00d5, 8'h04, 1'b1, 1'b0, fxd_pkg::T_SECOND_DMA_CONTROLLER_SMASK);
      cmp(16'(second_dma_controller_mask_o), 16'h000b);
      xfer(1'b1, 16'h00d4, 8'h03, 1'b1, 1'b0, fxd_pkg::T_SECOND_DMA_CONTROLLER_SMASK);
      cmp(16'(second_dma_controller_mask_o), 16'h0003);
      xfer(1'b1, 16'h00db, 8'h00, 1'b1, 1'b0, fxd_pkg::T_SECOND_DMA_CONTROLLER_MCLR);
      cmp(16'(second_dma_controller_mask_o), 16'h000f);
      xfer(1'b1, 16'h00dd, 8'h00, 1'b1, 1'b0, fxd_pkg::T_SECOND_DMA_CONTROLLER_CLR_MASK);
      cmp(16'(second_dma_controller_mask_o), 16'h0000);
      xfer(1'b1, 16'h00d9, 8'h00, 1'b1, 1'b0, fxd_pkg::T_SECOND_DMA_CONTROLLER_CLR_PTR);
      cmp(16'(second_dma_controller_mask_o), 16'h0000);
      xfer(1'b1, 16'h00d0, 8'h55, 1'b1, 1'b0, fxd_pkg::T_SECOND_DMA_CONTROLLER_CMD_STAT);
      rd(16'h00d1, 8'h00);
   endtask : t_second_dma_controller

   task automatic t_local;
      logic [15:0] la [6] = '{16'h0092, 16'h00b2, 16'h00b3, 16'h04d0, 16'h04d1, 16'h008f};
      for (int i = 0; i < 6; i++)
         host.io(1'b1, la[i], 8'(8'h5a + 8'(i * 17)));
      for (int i = 0; i < 6; i++)
         rd(la[i], 8'(8'h5a + 8'(i * 17)));
      rd(16'h009f, 8'h5a + 8'(5 * 17));
      rd(16'h008e, 8'h47);
   endtask : t_local

   initial
   begin
      reset_i = 1'b1;
      ce_i = 1'b1;
      rtc_ext_fwd_en_i = 1'b0;
      alias_fwd_en_i = 1'b0;
      do_reset();
      t_reset_vals();
      t_rtc();
      t_page_rsvd();
      t_page_low();
      t_ranges();
      t_unclaimed();
      t_second_dma_controller();
      t_local();
      // second reset mid-run must bring local bytes and the mask back
      do_reset();
      t_reset_vals();
      results();
   end
endmodule : tb

// file: include/fxd_dec_if.sv
// fxd_dec_if: address decode result and local byte store signals.
// assumes one clock domain; driven by the decoder top and its two leaves.
`timescale 1ns/1ns
interface fxd_dec_if;
   logic [15:0] addr;
   fxd_pkg::fxd_tgt_t tgt;
   logic fwd_wr;
   logic fwd_alias;
   logic fwd_rtc;
   logic local_hit;
   logic [3:0] idx;
   logic we;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport cls (input addr, output tgt, fwd_wr, fwd_alias, fwd_rtc, local_hit, idx);
   modport store (input we, idx, wdata, output rdata);
   modport top (output addr, we, wdata, input tgt, fwd_wr, fwd_alias, fwd_rtc, local_hit, idx, rdata);
endinterface : fxd_dec_if

// file: include/fxd_pkg.sv
// fxd_pkg: constants and types of the fixed i/o range decoder.
// assumes a 16-bit i/o address space and byte-wide i/o cycles.
package fxd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int IDX_W = 4;
   localparam int NUM_LOC = 14;
   // fixed addresses
   localparam logic [15:0] A_RTC_EXT = 16'h0073;
   localparam logic [15:0] A_PAGE_BASE = 16'h0080;
   localparam logic [15:0] A_PAGE_ALIAS = 16'h0090;
   localparam logic [15:0] A_PAGE_CH3 = 16'h0082;
   localparam logic [15:0] A_REFRESH = 16'h008F;
   localparam logic [15:0] A_REFRESH_ALIAS = 16'h009F;
   localparam logic [15:0] A_FAST_A20 = 16'h0092;
   localparam logic [15:0] A_PIC2_BASE = 16'h00A0;
   localparam logic [15:0] A_PWR_CTRL = 16'h00B2;
   localparam logic [15:0] A_PWR_STAT = 16'h00B3;
   localparam logic [15:0] A_SECOND_DMA_CONTROLLER_CHAN = 16'h00C0;
   localparam logic [15:0] A_SECOND_DMA_CONTROLLER_CTL = 16'h00D0;
   localparam logic [15:0] A_DISK_PRI_CMD = 16'h01F0;
   localparam logic [15:0] A_DISK_PRI_CTL = 16'h03F6;
   localparam logic [15:0] A_DISK_SEC_CMD = 16'h0170;
   localparam logic [15:0] A_DISK_SEC_CTL = 16'h0376;
   localparam logic [15:0] A_ELCR1 = 16'h04D0;
   localparam logic [15:0] A_ELCR2 = 16'h04D1;
   // local storage slots
   // slots 0-7 hold the eight reserved page locations, one each
   localparam logic [3:0] IDX_REFRESH = 4'h8;
   localparam logic [3:0] IDX_FAST_A20 = 4'h9;
   localparam logic [3:0] IDX_PWR_CTRL = 4'hA;
   localparam logic [3:0] IDX_PWR_STAT = 4'hB;
   localparam logic [3:0] IDX_ELCR1 = 4'hC;
   localparam logic [3:0] IDX_ELCR2 = 4'hD;
   // reset values
   localparam logic [7:0] LOC_RESET = 8'h00;
   localparam logic [3:0] SECOND_DMA_CONTROLLER_MASK_RESET = 4'h1;
   localparam logic [7:0] SECOND_DMA_CONTROLLER_STAT_RESET = 8'h00;
   // field positions of the single-channel mask write
   localparam int SMASK_BIT = 2;
   typedef enum logic [4:0] {
      T_NONE, T_RTC_EXT, T_PAGE_RSVD, T_PAGE_LOW, T_PAGE_REFRESH, T_FAST_A20,
      T_PIC2_CTRL, T_PIC2_MASK, T_PWR_MGMT, T_SECOND_DMA_CONTROLLER_CHAN, T_SECOND_DMA_CONTROLLER_CMD_STAT,
      T_SECOND_DMA_CONTROLLER_REQ, T_SECOND_DMA_CONTROLLER_SMASK, T_SECOND_DMA_CONTROLLER_MODE, T_SECOND_DMA_CONTROLLER_CLR_PTR, T_SECOND_DMA_CONTROLLER_MCLR,
      T_SECOND_DMA_CONTROLLER_CLR_MASK, T_SECOND_DMA_CONTROLLER_AMASK, T_DISK_PRI, T_DISK_SEC, T_ELCR
   } fxd_tgt_t;
   typedef enum {S_IDLE, S_DONE} fxd_state_t;
endpackage : fxd_pkg

// file: src/fxd_classify.sv
// fxd_classify: purely combinational map from i/o address to target.
// assumes the address is stable while the cycle is offered.
`timescale 1ns/1ns
module fxd_classify (
   fxd_dec_if.cls dec
);
   logic [15:0] a;
   always_comb
   begin
      a = dec.addr;
      dec.tgt = fxd_pkg::T_NONE;
      dec.fwd_wr = 1'b0;
      dec.fwd_alias = 1'b0;
      dec.fwd_rtc = 1'b0;
      dec.local_hit = 1'b0;
      dec.idx = 4'h0;
      if (a == fxd_pkg::A_RTC_EXT)
      begin
         dec.tgt = fxd_pkg::T_RTC_EXT;
         dec.fwd_rtc = 1'b1;
      end
      else if (a == fxd_pkg::A_REFRESH || a == fxd_pkg::A_REFRESH_ALIAS)
      begin
         dec.tgt = fxd_pkg::T_PAGE_REFRESH;
         dec.local_hit = 1'b1;
         dec.idx = fxd_pkg::IDX_REFRESH;
      end
      else if (a[15:4] == fxd_pkg::A_PAGE_BASE[15:4] || a[15:4] == fxd_pkg::A_PAGE_ALIAS[15:4])
      begin
         case (a[3:0])
            4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hC, 4'hD, 4'hE:
            begin
               dec.tgt = fxd_pkg::T_PAGE_RSVD;
               dec.local_hit = 1'b1;
               // distinct slot per location; alias shares its base slot
               case (a[3:0])
                  4'h0: dec.idx = 4'h0;
                  4'h4: dec.idx = 4'h1;
                  4'h5: dec.idx = 4'h2;
                  4'h6: dec.idx = 4'h3;
                  4'h8: dec.idx = 4'h4;
                  4'hC: dec.idx = 4'h5;
                  4'hD: dec.idx = 4'h6;
                  default: dec.idx = 4'h7;
               endcase
               dec.fwd_wr = (a[15:4] == fxd_pkg::A_PAGE_BASE[15:4]);
               dec.fwd_alias = (a[15:4] == fxd_pkg::A_PAGE_ALIAS[15:4]);
            end
            4'h1, 4'h3, 4'h7, 4'h9, 4'hA, 4'hB:
               dec.tgt = fxd_pkg::T_PAGE_LOW;
            4'h2:
               dec.tgt = (a == fxd_pkg::A_PAGE_CH3) ? fxd_pkg::T_PAGE_LOW : fxd_pkg::T_NONE;
            default:
               dec.tgt = fxd_pkg::T_NONE;
         endcase
         if (a == fxd_pkg::A_FAST_A20)
         begin
            dec.tgt = fxd_pkg::T_FAST_A20;
            dec.local_hit = 1'b1;
            dec.idx = fxd_pkg::IDX_FAST_A20;
         end
      end
      else if (a == fxd_pkg::A_PWR_CTRL || a == fxd_pkg::A_PWR_STAT)
      begin
         dec.tgt = fxd_pkg::T_PWR_MGMT;
         dec.local_hit = 1'b1;
         dec.idx = a[0] ? fxd_pkg::IDX_PWR_STAT : fxd_pkg::IDX_PWR_CTRL;
      end
      else if (a[15:5] == fxd_pkg::A_PIC2_BASE[15:5] && !a[1])
         dec.tgt = a[0] ? fxd_pkg::T_PIC2_MASK : fxd_pkg::T_PIC2_CTRL;
      else if (a[15:4] == fxd_pkg::A_SECOND_DMA_CONTROLLER_CHAN[15:4])
         dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_CHAN;
      else if (a[15:4] == fxd_pkg::A_SECOND_DMA_CONTROLLER_CTL[15:4])
      begin
         case (a[3:1])
            3'd0: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_CMD_STAT;
            3'd1: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_REQ;
            3'd2: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_SMASK;
            3'd3: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_MODE;
            3'd4: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_CLR_PTR;
            3'd5: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_MCLR;
            3'd6: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_CLR_MASK;
            default: dec.tgt = fxd_pkg::T_SECOND_DMA_CONTROLLER_AMASK;
         endcase
      end
      else if (a[15:3] == fxd_pkg::A_DISK_PRI_CMD[15:3] || a == fxd_pkg::A_DISK_PRI_CTL)
         dec.tgt = fxd_pkg::T_DISK_PRI;
      else if (a[15:3] == fxd_pkg::A_DISK_SEC_CMD[15:3] || a == fxd_pkg::A_DISK_SEC_CTL)
         dec.tgt = fxd_pkg::T_DISK_SEC;
      else if (a == fxd_pkg::A_ELCR1 || a == fxd_pkg::A_ELCR2)
      begin
         dec.tgt = fxd_pkg::T_ELCR;
         dec.local_hit = 1'b1;
         dec.idx = a[0] ? fxd_pkg::IDX_ELCR2 : fxd_pkg::IDX_ELCR1;
      end
   end
endmodule : fxd_classify

// file: src/fxd_decoder.sv
// fxd_decoder: fixed legacy i/o range decoder, one i/o cycle per request.
// assumes requests synchronous to clk_sys_i; answers one clock later.
`timescale 1ns/1ns
module fxd_decoder (
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // i/o cycle request
   input wire logic io_valid_i,
   input wire logic io_write_i,
   input wire logic [15:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   // forwarding controls
   input wire logic rtc_ext_fwd_en_i,
   input wire logic alias_fwd_en_i,
   // decode answer
   output logic done_o,
   output logic claim_o,
   output logic forward_o,
   output fxd_pkg::fxd_tgt_t target_o,
   output logic local_o,
   output logic [7:0] rdata_o,
   // second dma controller mask shadow
   output logic [3:0] second_dma_controller_mask_o
);
   fxd_dec_if dec ();

   fxd_classify u_classify (
      .dec(dec)
   );

   fxd_store u_store (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .dec(dec)
   );

   logic take;
   assign take = io_valid_i;
   assign dec.addr = io_addr_i;
   assign dec.wdata = io_wdata_i;
   // local store is written only for claimed local locations
   assign dec.we = take && io_write_i && dec.local_hit;

   // forwarding decision
   function automatic logic fwd_of(input logic wr, input logic fw, input logic fa, input logic fr,
                                   input logic rtc_en, input logic al_en);
      logic r;
      r = 1'b0;
      if (fr)
         r = rtc_en;
      else if (fw && wr)
         r = 1'b1;
      else if (fa && wr)
         r = al_en;
      return r;
   endfunction : fwd_of

   // answer registers
   fxd_pkg::fxd_state_t st_q, st_d;
   logic done_d, claim_d, fwd_d, local_d;
   logic claim_q, fwd_q, local_q;
   fxd_pkg::fxd_tgt_t tgt_d, tgt_q;
   logic [7:0] rdata_d, rdata_q;
   logic [3:0] mask_q, mask_d;
   logic [7:0] stat_q, stat_d;
   logic wr_take;

   always_comb
   begin
      st_d = st_q;
      done_d = 1'b0;
      claim_d = claim_q;
      fwd_d = fwd_q;
      local_d = local_q;
      tgt_d = tgt_q;
      rdata_d = rdata_q;
      case (st_q)
         fxd_pkg::S_IDLE, fxd_pkg::S_DONE:
         begin
            st_d = take ? fxd_pkg::S_DONE : fxd_pkg::S_IDLE;
            if (take)
            begin
               done_d = 1'b1;
               tgt_d = dec.tgt;
               claim_d = (dec.tgt != fxd_pkg::T_NONE);
               fwd_d = fwd_of(io_write_i, dec.fwd_wr, dec.fwd_alias, dec.fwd_rtc,
                              rtc_ext_fwd_en_i, alias_fwd_en_i);
               local_d = dec.local_hit || (dec.tgt == fxd_pkg::T_SECOND_DMA_CONTROLLER_AMASK)
                         || (dec.tgt == fxd_pkg::T_SECOND_DMA_CONTROLLER_CMD_STAT);
               rdata_d = 8'h00;
               if (!io_write_i && dec.local_hit)
                  rdata_d = dec.rdata;
               else if (!io_write_i && dec.tgt == fxd_pkg::T_SECOND_DMA_CONTROLLER_AMASK)
                  rdata_d = {4'h0, mask_q};
               else if (!io_write_i && dec.tgt == fxd_pkg::T_SECOND_DMA_CONTROLLER_CMD_STAT)
                  rdata_d = stat_q;
            end
         end
         default:
            st_d = fxd_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         st_q <= fxd_pkg::S_IDLE;
         done_o <= 1'b0;
         claim_q <= 1'b0;
         fwd_q <= 1'b0;
         local_q <= 1'b0;
         tgt_q <= fxd_pkg::T_NONE;
         rdata_q <= 8'h00;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
         done_o <= done_d;
         claim_q <= claim_d;
         fwd_q <= fwd_d;
         local_q <= local_d;
         tgt_q <= tgt_d;
         rdata_q <= rdata_d;
      end
   end

   assign claim_o = claim_q;
   assign forward_o = fwd_q;
   assign local_o = local_q;
   assign target_o = tgt_q;
   assign rdata_o = rdata_q;

   // mask and status shadow of the second dma controller; the unit itself
   // keeps the full state, this copy answers reads at the decoder and drives second_dma_controller_mask_o.
   assign wr_take = take && io_write_i;

   always_comb
   begin
      mask_d = mask_q;
      stat_d = stat_q;
      if (wr_take)
      begin
         case (dec.tgt)
            fxd_pkg::T_SECOND_DMA_CONTROLLER_SMASK:
               mask_d[io_wdata_i[1:0]] = io_wdata_i[fxd_pkg::SMASK_BIT];
            fxd_pkg::T_SECOND_DMA_CONTROLLER_AMASK:
               mask_d = io_wdata_i[3:0];
            fxd_pkg::T_SECOND_DMA_CONTROLLER_MCLR:
               mask_d = 4'hF;
            fxd_pkg::T_SECOND_DMA_CONTROLLER_CLR_MASK:
               mask_d = 4'h0;
            fxd_pkg::T_SECOND_DMA_CONTROLLER_CMD_STAT:
               stat_d = fxd_pkg::SECOND_DMA_CONTROLLER_STAT_RESET;
            default:
               mask_d = mask_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mask_q <= fxd_pkg::SECOND_DMA_CONTROLLER_MASK_RESET;
         stat_q <= fxd_pkg::SECOND_DMA_CONTROLLER_STAT_RESET;
         second_dma_controller_mask_o <= fxd_pkg::SECOND_DMA_CONTROLLER_MASK_RESET;
      end
      else if (ce_i)
      begin
         mask_q <= mask_d;
         stat_q <= stat_d;
         second_dma_controller_mask_o <= mask_d;
      end
   end

   // checks
   sequence s_req(logic [15:0] ad);
      ce_i && io_valid_i && io_addr_i == ad;
   endsequence

   sequence s_wr(logic [15:0] ad);
      ce_i && io_valid_i && io_write_i && io_addr_i == ad;
   endsequence

   sequence s_rd(logic [15:0] ad);
      ce_i && io_valid_i && !io_write_i && io_addr_i == ad;
   endsequence

   chk_rtc_ext_fwd: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(fxd_pkg::A_RTC_EXT) |=> claim_o && forward_o == $past(rtc_ext_fwd_en_i)
   ) else $error("rtc extended port forwarding wrong");

   chk_rsvd_wr_fwd: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_wr(16'h0084) |=> done_o && forward_o && local_o
   ) else $error("reserved page write not forwarded");

   chk_rsvd_keep: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_wr(16'h0086) ##1 (ce_i && !io_valid_i) [*2] ##1 s_rd(16'h0086)
      |=> rdata_o == $past(io_wdata_i, 4)
   ) else $error("reserved page location lost its value");

   chk_alias_fwd: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_wr(16'h0098) |=> forward_o == $past(alias_fwd_en_i)
   ) else $error("alias write forwarding wrong");

   chk_low_page: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(16'h0097) or s_req(16'h0082) |=> claim_o && !forward_o && target_o == fxd_pkg::T_PAGE_LOW
   ) else $error("low page register misrouted");

   chk_ch3_no_alias: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(16'h0092 + 16'h0000) |=> target_o == fxd_pkg::T_FAST_A20
   ) else $error("alias range stole fast a20 port");

   chk_refresh_local: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(fxd_pkg::A_REFRESH_ALIAS) |=> target_o == fxd_pkg::T_PAGE_REFRESH && !forward_o
   ) else $error("refresh page alias misrouted");

   chk_a20_reset: assert property (
      @(posedge clk_sys_i)
      ($fell(reset_i) && !io_valid_i) ##1 (ce_i && !io_valid_i) ##1 s_rd(fxd_pkg::A_FAST_A20)
      |=> rdata_o == 8'h00
   ) else $error("fast a20 register not zero after reset");

   chk_pic2_alias: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(16'h00BD) |=> target_o == fxd_pkg::T_PIC2_MASK && claim_o && !forward_o
   ) else $error("interrupt controller mask alias missed");

   chk_second_dma_controller_chan: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(16'h00CF) |=> target_o == fxd_pkg::T_SECOND_DMA_CONTROLLER_CHAN && !forward_o
   ) else $error("channel port alias missed");

   chk_amask_rw: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_wr(16'h00DE) ##1 (ce_i && !io_valid_i) ##1 s_rd(16'h00DF)
      |=> rdata_o == {4'h0, $past(io_wdata_i[3:0], 3)}
   ) else $error("all-mask read back wrong");

   chk_disk_sec: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(fxd_pkg::A_DISK_SEC_CTL) |=> target_o == fxd_pkg::T_DISK_SEC && !forward_o
   ) else $error("secondary disk control misrouted");

   chk_elcr_local: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(fxd_pkg::A_ELCR2) |=> local_o && claim_o && !forward_o
   ) else $error("edge level register misrouted");

   chk_no_claim: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_req(16'h0300) |=> done_o && !claim_o && !forward_o
   ) else $error("unmapped address claimed");
endmodule : fxd_decoder

// file: src/fxd_store.sv
// fxd_store: byte locations kept inside the decoder, all reset to zero.
// assumes writes arrive as single-cycle enables from the decoder top.
`timescale 1ns/1ns
module fxd_store (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   fxd_dec_if.store dec
);
   logic [7:0] loc_q [fxd_pkg::NUM_LOC];
   logic [7:0] loc_d [fxd_pkg::NUM_LOC];
   for (genvar g = 0; g < fxd_pkg::NUM_LOC; g++)
   begin : g_loc
      always_comb
      begin
         loc_d[g] = loc_q[g];
         if (dec.we && dec.idx == 4'(g))
            loc_d[g] = dec.wdata;
      end
      always_ff @(posedge clk_sys_i or posedge reset_i)
      begin
         if (reset_i)
            loc_q[g] <= fxd_pkg::LOC_RESET;
         else if (ce_i)
            loc_q[g] <= loc_d[g];
      end
   end
   assign dec.rdata = (dec.idx < 4'(fxd_pkg::NUM_LOC)) ? loc_q[dec.idx] : fxd_pkg::LOC_RESET;
endmodule : fxd_store
